// *** common/bsd_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types for the bundle syllable decoder.
package bsd_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// Syllable layout.
	localparam int SLOTS = 4; // Most syllables in one bundle.
	localparam int SYL_W = 32; // Width of one syllable.
	localparam int STOP_BIT = 31; // Terminator flag position.
	localparam int ASSOC_BIT = 23; // Extension association: 0 left, 1 right.
	localparam int EXT_W = 23; // Payload bits of an extension syllable.
	localparam int SHORT_W = 9; // Width of the short constant field.
	localparam int SHORT_LSB = 12; // Position of the short constant field.
	localparam int IMM_FORM_BIT = 27; // Set when an operation uses a constant.
	localparam int EXT_TAG_LSB = 24; // Low bit of the extension marker field.
	localparam logic [6:0] EXT_TAG = 7'h5A; // Marker value for an extension.
	localparam int RESULT_W = 40; // Width of a raw arithmetic result.
	////////////////////////////////////////////////////////////////////////////////
	// Register map and reset values.
	localparam logic [11:0] OFF_CTRL = 12'h000; // Decoder enable.
	localparam logic [11:0] OFF_STATUS = 12'h004; // Sticky events, read clears.
	localparam logic [11:0] OFF_MASK = 12'h008; // Interrupt mask.
	localparam logic [11:0] OFF_COUNT = 12'h00C; // Committed bundle count.
	localparam logic CTRL_RST = 1'b1; // Decoder runs after reset.
	localparam logic [2:0] MASK_RST = 3'h0; // All events masked after reset.
	localparam int EV_W = 3; // Number of event bits.
	localparam int EV_DONE = 0; // A bundle committed.
	localparam int EV_MALFORMED = 1; // Four syllables without a terminator.
	localparam int EV_EXCEPT = 2; // A bundle was squashed by an exception.
	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [2:0] {
		PH_COLLECT, PH_DECODE, PH_ISSUE, PH_WAIT, PH_COMMIT
	} bsd_phase_t;
	// One decoded slot as handed to the execution units.
	typedef struct packed {
		logic is_op; // Slot holds an operation.
		logic is_ext; // Slot holds an extension value.
		logic is_imm; // Operation uses a constant operand.
		logic extended; // Constant was widened by a neighbour.
		logic [31:0] imm; // Resolved signed constant.
		logic [31:0] syl; // Raw syllable.
	} bsd_op_t;
	// Whole state of the decoder.
	typedef struct packed {
		bsd_phase_t phase;
		logic [SLOTS-1:0][SYL_W-1:0] slots;
		logic [2:0] count;
		logic [2:0] len;
		bsd_op_t [SLOTS-1:0] ops;
		logic [SLOTS-1:0] wr_en;
		logic [SLOTS-1:0][31:0] wr_data;
		logic malformed;
		logic ctrl_en;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [31:0] bundles;
		logic [31:0] prdata;
		logic pslverr;
	} bsd_state_t;
endpackage : bsd_pkg

// *** verilog/bsd_decoder.sv ***
`timescale 1ns/1ns
module bsd_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic fetch_valid,
	input wire logic [31:0] fetch_syllable,
	output logic fetch_ready,
	output logic issue_valid,
	output bsd_pkg::bsd_op_t [3:0] issue_ops,
	input wire logic exec_done,
	input wire logic [3:0] exec_exception,
	input wire logic [3:0][39:0] exec_result,
	output logic [3:0] wr_en,
	output logic [3:0][31:0] wr_data,
	output logic bundle_malformed
);
	////////////////////////////////////////////////////////////////////////////////
	// Decoding helpers.

	// An extension syllable carries the fixed marker; anything else is an operation.
	function automatic logic is_ext(input logic [31:0] syl);
		is_ext = (syl[bsd_pkg::EXT_TAG_LSB +: 7] == bsd_pkg::EXT_TAG);
	endfunction : is_ext

	// Decodes slot idx of a bundle of len syllables, pairing neighbouring extensions.
	function automatic bsd_pkg::bsd_op_t decode_slot(input logic [3:0][31:0] s,
		input logic [2:0] len, input logic [2:0] idx);
		bsd_pkg::bsd_op_t op;
		logic [31:0] left;
		logic [31:0] right;
		logic from_left;
		logic from_right;
		logic [8:0] short_c;
		op = '0;
		left = (idx == 3'h0) ? 32'h00000000 : s[idx - 3'h1];
		right = (idx == 3'h3) ? 32'h00000000 : s[idx + 3'h1];
		short_c = s[idx][bsd_pkg::SHORT_LSB +: bsd_pkg::SHORT_W];
		// Right-associating extension before, or left-associating after, in bundle.
		from_left = (idx != 3'h0) && is_ext(left) && left[bsd_pkg::ASSOC_BIT];
		from_right = ((idx + 3'h1) < len) && is_ext(right)
			&& !right[bsd_pkg::ASSOC_BIT];
		op.syl = s[idx];
		op.is_ext = (idx < len) && is_ext(s[idx]);
		op.is_op = (idx < len) && !is_ext(s[idx]);
		op.is_imm = op.is_op && s[idx][bsd_pkg::IMM_FORM_BIT];
		op.extended = op.is_imm && (from_left || from_right);
		if (op.is_imm && from_left) begin
			op.imm = {left[bsd_pkg::EXT_W-1:0], 9'h000} + {23'h000000, short_c};
		end else if (op.is_imm && from_right) begin
			op.imm = {right[bsd_pkg::EXT_W-1:0], 9'h000} + {23'h000000, short_c};
		end else if (op.is_imm) begin
			op.imm = {{23{short_c[8]}}, short_c};
		end else begin
			op.imm = 32'h00000000;
		end
		decode_slot = op;
	endfunction : decode_slot

	////////////////////////////////////////////////////////////////////////////////
	// State and per-slot decode.
	bsd_pkg::bsd_state_t st; // Registered state.
	bsd_pkg::bsd_state_t next_st; // Next state.
	bsd_pkg::bsd_op_t [3:0] decoded; // Combinational decode of the held bundle.
	logic setup; // APB setup phase.
	logic access; // APB access phase completing.
	localparam int EV_W_L = bsd_pkg::EV_W; // Width of the event vector.
	logic [EV_W_L-1:0] events; // Events raised this cycle.

	// Each slot is decoded against its neighbours; all four run in parallel.
	for (genvar g = 0; g < 4; g++) begin : g_slot
		assign decoded[g] = decode_slot(st.slots, st.len, 3'(g));
	end

	assign setup = psel && !penable;
	assign access = psel && penable;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Collects syllables, decodes, issues, waits for execution and commits.
	always_comb begin
		next_st = st;
		events = '0;
		next_st.malformed = 1'b0;
		next_st.wr_en = '0;
		case (st.phase)
			bsd_pkg::PH_COLLECT: begin
				// Syllables only flow while the decoder is enabled.
				if (fetch_valid && st.ctrl_en) begin
					next_st.slots[st.count[1:0]] = fetch_syllable;
					if (fetch_syllable[bsd_pkg::STOP_BIT]) begin
						// Terminator closes the bundle; next syllable starts anew.
						next_st.len = st.count + 3'h1;
						next_st.count = 3'h0;
						next_st.phase = bsd_pkg::PH_DECODE;
					end else if (st.count == 3'h3) begin
						// Fourth syllable with no terminator: discard everything.
						next_st.count = 3'h0;
						next_st.malformed = 1'b1;
						events[bsd_pkg::EV_MALFORMED] = 1'b1;
					end else begin
						next_st.count = st.count + 3'h1;
					end
				end
			end
			bsd_pkg::PH_DECODE: begin
				// Freeze the decode so the issued operands come from flip-flops.
				next_st.ops = decoded;
				next_st.phase = bsd_pkg::PH_ISSUE;
			end
			bsd_pkg::PH_ISSUE: begin
				next_st.phase = bsd_pkg::PH_WAIT;
			end
			bsd_pkg::PH_WAIT: begin
				// Nothing architectural moves until execution reports back.
				if (exec_done) begin
					if (|exec_exception) begin
						events[bsd_pkg::EV_EXCEPT] = 1'b1;
						next_st.phase = bsd_pkg::PH_COLLECT;
					end else begin
						for (int i = 0; i < 4; i++) begin
							next_st.wr_en[i] = st.ops[i].is_op;
							next_st.wr_data[i] = exec_result[i][31:0];
						end
						next_st.phase = bsd_pkg::PH_COMMIT;
					end
				end
			end
			bsd_pkg::PH_COMMIT: begin
				// Writes land now, ahead of the next bundle's issue.
				events[bsd_pkg::EV_DONE] = 1'b1;
				next_st.bundles = st.bundles + 32'h00000001;
				next_st.phase = bsd_pkg::PH_COLLECT;
			end
			default: begin
				next_st.phase = bsd_pkg::PH_COLLECT;
			end
		endcase
		// Register read data and error are captured in the setup phase.
		if (setup) begin
			next_st.pslverr = 1'b0;
			if (paddr == bsd_pkg::OFF_CTRL) begin
				next_st.prdata = {31'h00000000, st.ctrl_en};
			end else if (paddr == bsd_pkg::OFF_STATUS) begin
				next_st.prdata = {29'h00000000, st.status};
			end else if (paddr == bsd_pkg::OFF_MASK) begin
				next_st.prdata = {29'h00000000, st.mask};
			end else if (paddr == bsd_pkg::OFF_COUNT) begin
				next_st.prdata = st.bundles;
			end else begin
				next_st.prdata = 32'h00000000;
				next_st.pslverr = 1'b1;
			end
		end
		// Writes and read-clear take effect at the completing edge.
		if (access && pwrite && paddr == bsd_pkg::OFF_CTRL) begin
			next_st.ctrl_en = pwdata[0];
		end else if (access && pwrite && paddr == bsd_pkg::OFF_MASK) begin
			next_st.mask = pwdata[bsd_pkg::EV_W-1:0];
		end
		// Only bits shown to software are cleared; a new event wins over the clear.
		if (access && !pwrite && paddr == bsd_pkg::OFF_STATUS) begin
			next_st.status = (st.status & ~st.prdata[bsd_pkg::EV_W-1:0]) | events;
		end else begin
			next_st.status = st.status | events;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// All state resets to constants and then follows the next-state copy.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.phase <= bsd_pkg::PH_COLLECT;
			st.ctrl_en <= bsd_pkg::CTRL_RST;
			st.mask <= bsd_pkg::MASK_RST;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = st.pslverr && access;
	assign irq = |(st.status & st.mask);
	assign fetch_ready = (st.phase == bsd_pkg::PH_COLLECT) && st.ctrl_en;
	assign issue_valid = (st.phase == bsd_pkg::PH_ISSUE);
	assign issue_ops = st.ops;
	assign wr_en = st.wr_en;
	assign wr_data = st.wr_data;
	assign bundle_malformed = st.malformed;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	// A syllable with its terminator taken while collecting.
	sequence s_stop_taken;
		fetch_valid && fetch_ready && fetch_syllable[bsd_pkg::STOP_BIT];
	endsequence
	// The bundle then goes through decode and issue on the next two edges.
	sequence s_decode_issue;
		(st.phase == bsd_pkg::PH_DECODE) ##1 issue_valid;
	endsequence

	a_stop_closes: assert property (@(posedge pclk) disable iff (!presetn)
		s_stop_taken |=> s_decode_issue)
		else $error("Terminator did not close the bundle.");

	a_count_bound: assert property (@(posedge pclk) disable iff (!presetn)
		st.count <= 3'h3 && (st.phase == bsd_pkg::PH_COLLECT || st.len <= 3'h4))
		else $error("Bundle length out of range.");

	a_malformed_drop: assert property (@(posedge pclk) disable iff (!presetn)
		fetch_valid && fetch_ready && st.count == 3'h3
		&& !fetch_syllable[bsd_pkg::STOP_BIT] |=> bundle_malformed && !issue_valid
		##1 !issue_valid && (st.phase == bsd_pkg::PH_COLLECT || st.phase == bsd_pkg::PH_DECODE))
		else $error("Malformed bundle was not dropped.");

	a_ext_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid |-> !(issue_ops[0].is_ext && issue_ops[0].is_op)
		&& !(issue_ops[1].is_ext && issue_ops[1].is_op))
		else $error("Slot decoded as both kinds.");

	a_short_sign: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid && issue_ops[0].is_imm && !issue_ops[0].extended
		|-> issue_ops[0].imm == {{23{issue_ops[0].syl[20]}}, issue_ops[0].syl[20:12]})
		else $error("Short constant not sign extended.");

	a_ext_value: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid && issue_ops[0].is_imm && issue_ops[1].is_ext
		&& !issue_ops[1].syl[23] |-> issue_ops[0].extended
		&& issue_ops[0].imm[31:9] == issue_ops[1].syl[22:0])
		else $error("Left extension not bound.");

	a_precommit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase != bsd_pkg::PH_COMMIT |-> wr_en == 4'h0)
		else $error("State written outside commit.");

	a_exc_squash: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == bsd_pkg::PH_WAIT && exec_done && |exec_exception
		|=> wr_en == 4'h0 ##1 wr_en == 4'h0)
		else $error("Squashed bundle still wrote.");

	a_trunc_write: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == bsd_pkg::PH_WAIT && exec_done && !(|exec_exception)
		|=> wr_data[0] == $past(exec_result[0][31:0])
		&& wr_en == {issue_ops[3].is_op, issue_ops[2].is_op,
		issue_ops[1].is_op, issue_ops[0].is_op})
		else $error("Write data not truncated result.");

	// A clean or a faulting end of execution while the bundle waits.
	sequence s_exec_clean;
		st.phase == bsd_pkg::PH_WAIT && exec_done && !(|exec_exception);
	endsequence
	sequence s_exec_fault;
		st.phase == bsd_pkg::PH_WAIT && exec_done && (|exec_exception);
	endsequence
	// Commit takes one cycle, then the decoder collects again with writes off.
	sequence s_commit_once;
		(st.phase == bsd_pkg::PH_COMMIT) ##1 (st.phase == bsd_pkg::PH_COLLECT && wr_en == 4'h0);
	endsequence

	// Issue lasts exactly one cycle per bundle.
	a_issue_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid |=> !issue_valid)
		else $error("Issue held for more than one cycle.");

	// An issued bundle has one to four syllables, and slot 3 is live only in a four-syllable bundle.
	a_issue_length: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid |-> st.len >= 3'h1 && st.len <= 3'h4
		&& (st.len == 3'h4 || !(issue_ops[3].is_op || issue_ops[3].is_ext)))
		else $error("Issued bundle length out of range.");

	// A right-binding extension in slot 0 widens the operation in slot 1.
	a_right_ext: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid && issue_ops[1].is_imm && issue_ops[0].is_ext && issue_ops[0].syl[23]
		|-> issue_ops[1].extended && issue_ops[1].imm[31:9] == issue_ops[0].syl[22:0]
		&& issue_ops[1].imm[8:0] == issue_ops[1].syl[20:12])
		else $error("Right extension not bound.");

	// The low nine bits of the slot 1 constant always come from the short field.
	a_short_field: assert property (@(posedge pclk) disable iff (!presetn)
		issue_valid && issue_ops[1].is_imm
		|-> issue_ops[1].imm[8:0] == issue_ops[1].syl[bsd_pkg::SHORT_LSB +: bsd_pkg::SHORT_W])
		else $error("Short field lost from the constant.");

	// A clean end of execution leads through one commit cycle back to collecting.
	a_commit_steps: assert property (@(posedge pclk) disable iff (!presetn)
		s_exec_clean |=> s_commit_once)
		else $error("Commit did not follow clean execution.");

	// Every commit adds exactly one to the bundle count and marks it in status.
	a_commit_count: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == bsd_pkg::PH_COMMIT
		|=> st.bundles == $past(st.bundles) + 32'h00000001 && st.status[bsd_pkg::EV_DONE])
		else $error("Commit not counted.");

	// A faulting bundle returns to collecting, records the squash and is not counted.
	a_squash_event: assert property (@(posedge pclk) disable iff (!presetn)
		s_exec_fault |=> st.phase == bsd_pkg::PH_COLLECT && st.status[bsd_pkg::EV_EXCEPT]
		&& st.bundles == $past(st.bundles))
		else $error("Squashed bundle not recorded.");

	// While execution is still running nothing is written and fetch stays closed.
	a_wait_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		st.phase == bsd_pkg::PH_WAIT && !exec_done
		|=> st.phase == bsd_pkg::PH_WAIT && wr_en == 4'h0 && !fetch_ready)
		else $error("State moved before commit.");

	// The slot 1 and slot 3 writes keep only the low register-width bits of their results.
	a_trunc_high: assert property (@(posedge pclk) disable iff (!presetn)
		s_exec_clean |=> wr_data[3] == $past(exec_result[3][31:0])
		&& wr_data[1] == $past(exec_result[1][31:0]))
		else $error("Upper write data not truncated result.");

	// The malformed flag is a one-cycle pulse, recorded in status, with no issue.
	a_malformed_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		bundle_malformed |-> !issue_valid && st.status[bsd_pkg::EV_MALFORMED]
		##1 !bundle_malformed)
		else $error("Malformed flag misbehaved.");

endmodule : bsd_decoder

// *** sim/bsd_partner.sv ***
`timescale 1ns/1ns
////////////////////////////////////////
// Fetch queue and execution pipeline that stand around the decoder.
module bsd_partner (
	output logic fetch_valid,
	output logic [31:0] fetch_syllable,
	output logic exec_done,
	output logic [3:0] exec_exception,
	output logic [3:0][39:0] exec_result,
	input wire logic pclk,
	input wire logic presetn,
	input wire logic fetch_ready,
	input wire logic issue_valid
);
	logic [31:0] fifo [$]; // Syllables waiting to be offered.
	logic [3:0] exc_next; // Exceptions raised for the next bundle.
	logic fire; // Execution ends at this edge.
	int lat; // Execution delay in cycles.
	int cnt; // Cycles left until the result is handed back.
	initial begin
		fetch_valid = 1'b0;
		fetch_syllable = 32'h0;
		exec_done = 1'b0;
		exec_exception = 4'h0;
		exec_result = {4{40'h0}};
		exc_next = 4'h0;
		lat = 0;
		cnt = 0;
	end
	// The bench queues bundles that keep the encoding restrictions.
	task automatic push(input logic [31:0] s);
		fifo.push_back(s);
	endtask : push
	////////////////////////////////////////
	// A syllable stays offered until taken; idle syllable, exception and result lines toggle every cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fetch_valid <= 1'b0;
			exec_done <= 1'b0;
			cnt = 0;
		end else begin
			if (fetch_valid && fetch_ready) begin
				void'(fifo.pop_front());
			end
			fetch_valid <= (fifo.size() > 0);
			if (fifo.size() > 0) begin
				fetch_syllable <= fifo[0];
			end else begin
				fetch_syllable <= ~fetch_syllable;
			end
			fire = issue_valid ? (lat == 0) : (cnt == 1);
			exec_done <= fire;
			exec_exception <= fire ? exc_next : ~exec_exception;
			for (int k = 0; k < 4; k++) begin
				exec_result[k] <= fire ? 40'hC312345670 + 40'(k) : ~exec_result[k];
			end
			cnt = issue_valid ? lat : ((cnt > 0) ? cnt - 1 : 0);
		end
	end
endmodule : bsd_partner

// *** sim/bsd_decoder_bench.sv ***
`timescale 1ns/1ns
////////////////////////////////////////
// Self-checking bench: register traffic plus whole bundles.
module bsd_decoder_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, iss, mal;
	logic fetch_valid, fetch_ready, issue_valid, exec_done, bundle_malformed;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, fetch_syllable;
	logic [3:0] exec_exception, wr_en, wen;
	logic [3:0][39:0] exec_result;
	logic [3:0][31:0] wr_data, wd, four;
	bsd_pkg::bsd_op_t [3:0] issue_ops, ops;
	int fails, comparisons;
	bsd_decoder i_bsd_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .fetch_valid, .fetch_syllable, .fetch_ready,
		.issue_valid, .issue_ops, .exec_done, .exec_exception, .exec_result, .wr_en,
		.wr_data, .bundle_malformed);
	bsd_partner i_bsd_partner (.pclk, .presetn, .fetch_valid, .fetch_syllable,
		.fetch_ready, .issue_valid, .exec_done, .exec_exception, .exec_result);
	// The clock runs at 20 MHz.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	////////////////////////////////////////
	// Prints the counts and the verdict, then stops.
	task automatic report_and_stop();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop
	// Compares one value with its expectation.
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One register transfer; the answer is taken at the edge that sees pready.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) begin
				q = prdata;
				e = pslverr;
				psel <= 1'b0;
				penable <= 1'b0;
				return;
			end
		end
		fails++;
		report_and_stop();
	endtask : apb
	// Reads a register and compares it.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	// Queues a bundle and collects issue, writes and the malformed pulse.
	task automatic run(input int n, input logic [3:0][31:0] s, input logic [3:0] x, input int l);
		#1;
		iss = 1'b0;
		mal = 1'b0;
		wen = 4'h0;
		i_bsd_partner.exc_next = x;
		i_bsd_partner.lat = l;
		for (int i = 0; i < n; i++) begin
			i_bsd_partner.push(s[i]);
		end
		for (int i = 0; i < 60; i++) begin
			@(posedge pclk);
			#1;
			if (issue_valid === 1'b1) begin
				iss = 1'b1;
				ops = issue_ops;
			end
			if (wr_en !== 4'h0) begin
				wen = wr_en;
				wd = wr_data;
			end
			if (bundle_malformed === 1'b1) begin
				mal = 1'b1;
			end
			if ((iss || mal) && fetch_ready === 1'b1) begin
				return;
			end
		end
		fails++;
		report_and_stop();
	endtask : run
	// Builds a constant-form operation.
	function automatic logic [31:0] op(input logic stop, input logic [8:0] sh);
		// Destination field stays at register zero, never the return link register.
		return {stop, 3'h0, 1'b1, 6'h0, sh, 12'h0};
	endfunction : op
	// Builds an extension syllable.
	function automatic logic [31:0] ext(input logic stop, input logic asc, input logic [22:0] p);
		return {stop, bsd_pkg::EXT_TAG, asc, p};
	endfunction : ext
	////////////////////////////////////////
	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fails = 0;
		comparisons = 0;
		repeat (2) @(posedge pclk);
		chk({pready, pslverr, irq, fetch_ready, issue_valid, wr_en, bundle_malformed}, 10'h240);
		presetn <= 1'b1;
		rd(bsd_pkg::OFF_CTRL, 32'h1);
		rd(bsd_pkg::OFF_STATUS, 32'h0);
		rd(bsd_pkg::OFF_MASK, 32'h0);
		rd(bsd_pkg::OFF_COUNT, 32'h0);
		rd(12'h010, 32'h0);
		chk(e, 1'b1);
		apb(1'b1, bsd_pkg::OFF_CTRL, 32'h0);
		rd(bsd_pkg::OFF_CTRL, 32'h0);
		chk(fetch_ready, 1'b0);
		apb(1'b1, bsd_pkg::OFF_CTRL, 32'h1);
		apb(1'b1, bsd_pkg::OFF_MASK, 32'h4);
		$display("test registers done");
		// A right-binding extension widens the operation after it.
		run(2, {64'h0, op(1'b1, 9'h1A5), ext(1'b0, 1'b1, 23'h3ABCDE)}, 4'h0, 0);
		chk(ops[0].is_ext, 1'b1);
		chk(ops[1].is_op, 1'b1);
		chk(ops[1].extended, 1'b1);
		chk(ops[1].imm, {23'h3ABCDE, 9'h1A5});
		chk(wen, 4'h2);
		chk(wd[1], 32'h12345671);
		// A lone negative short constant is sign-extended.
		run(1, {96'h0, op(1'b1, 9'h1F0)}, 4'h0, 5);
		chk(ops[0].imm, 32'hFFFFFFF0);
		chk(ops[0].extended, 1'b0);
		chk(wen, 4'h1);
		// A left-binding extension widens the operation before it.
		run(2, {64'h0, ext(1'b1, 1'b0, 23'h000001), op(1'b0, 9'h005)}, 4'h0, 1);
		chk(ops[0].imm, 32'h00000205);
		$display("test constants done");
		four = {op(1'b1, 9'h0), op(1'b0, 9'h0), op(1'b0, 9'h0), op(1'b0, 9'h0)};
		run(4, four, 4'h0, 2);
		chk(wen, 4'hF);
		chk(wd[3], 32'h12345673);
		rd(bsd_pkg::OFF_COUNT, 32'h4);
		chk(irq, 1'b0);
		// One faulting slot squashes every write of the bundle.
		run(4, four, 4'h4, 0);
		chk(iss, 1'b1);
		chk(wen, 4'h0);
		rd(bsd_pkg::OFF_MASK, 32'h4);
		chk(irq, 1'b1);
		rd(bsd_pkg::OFF_STATUS, 32'h5);
		rd(bsd_pkg::OFF_STATUS, 32'h0);
		chk(irq, 1'b0);
		rd(bsd_pkg::OFF_COUNT, 32'h4);
		$display("test commit done");
		// Four syllables without a terminator are dropped.
		run(4, {op(1'b0, 9'h0), op(1'b0, 9'h0), op(1'b0, 9'h0), op(1'b0, 9'h0)}, 4'h0, 0);
		chk(mal, 1'b1);
		chk(iss, 1'b0);
		rd(bsd_pkg::OFF_STATUS, 32'h2);
		$display("test malformed done");
		report_and_stop();
	end
endmodule : bsd_decoder_bench
